/* rtl/frtt_pkg.sv */
// Package: register map, fields and timing for the FlexRay test and timing block
`default_nettype none
package frtt_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CMD      = 8'h00; // host command field
  localparam logic [7:0] OFS_STATUS   = 8'h04; // memory wipe / activity / errs
  localparam logic [7:0] OFS_TIMER    = 8'h08; // relative timer control
  localparam logic [7:0] OFS_TEST     = 8'h0C; // test multiplexer, page select
  localparam logic [7:0] OFS_IBREQ    = 8'h10; // input buffer request write
  localparam logic [7:0] OFS_IBDATA   = 8'h14; // input buffer data window
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18; // sticky events, write 1 clear
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C; // interrupt mask

  // ==========================================================
  // Field positions and codes
  localparam logic [3:0] CMD_WIPE        = 4'b1100; // wipe_message_memory_cmd
  localparam int         TMR_RUN_BIT     = 0;
  localparam int         TMR_CONT_BIT    = 1;
  localparam int         TMR_CNT_LSB     = 16;
  localparam int         TST_TMC_LSB     = 0;
  localparam int         TST_PAG1_BIT    = 4;
  localparam int         TST_PAG2_BIT    = 5;
  localparam int         TST_TX_BIT      = 8;
  localparam int         TST_TXEN_BIT    = 9;
  localparam logic [1:0] TMC_NORMAL      = 2'd0;
  localparam logic [1:0] TMC_RAMTEST     = 2'd1;
  localparam logic [1:0] TMC_IOTEST      = 2'd2;
  localparam int         ST_WIPE_BIT     = 0;
  localparam int         ST_ACT_BIT      = 1;
  localparam int         ST_SWAP_BIT     = 2;
  localparam int         ST_CERR_LSB     = 4;
  localparam int         IRQ_TIMER_BIT   = 0;
  localparam int         IRQ_WIPE_BIT    = 1;
  localparam int         IRQ_CERR_BIT    = 2;
  localparam int         IRQ_W           = 3;

  // Coding error report codes
  localparam logic [1:0] CERR_NONE = 2'd0;
  localparam logic [1:0] CERR_CRC  = 2'd1;
  localparam logic [1:0] CERR_FES  = 2'd2;

  // ==========================================================
  // Memory shape and timing
  localparam int          PAGE_ENTRIES = 64;
  localparam int          IB_ADDR_W    = 8;  // buffer, page, 6-bit entry
  localparam int          WIPE_CYCLES  = 2049;
  localparam logic [11:0] WIPE_LAST    = 12'(WIPE_CYCLES - 1);
  localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
  localparam logic [15:0] TMR_RESET    = 16'h0000;
endpackage : frtt_pkg
`default_nettype wire

/* rtl/frtt_core.sv */
// FlexRay test and timing block: timer, input buffers, rx filter, RAM wipe
`default_nettype none

module frtt_core
  import frtt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        macrotick,
  input  wire logic        rx_line,
  input  wire logic        fes_error,
  input  wire logic        crc_error,
  input  wire logic        frame_end,
  output logic             channel_transmit_line,
  output logic             channel_transmit_enable_line,
  output logic             timer_tick,
  output logic             irq
);

  // ==========================================================
  // Input synchronisers
  // Reset values match each pin's idle level: no false edge
  logic [1:0] mt_sync_q, rx_sync_q, fes_sync_q, crc_sync_q, fe_sync_q;
  logic       mt_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mt_sync_q  <= 2'b00;
      rx_sync_q  <= 2'b11;
      fes_sync_q <= 2'b00;
      crc_sync_q <= 2'b00;
      fe_sync_q  <= 2'b00;
      mt_prev_q  <= 1'b0;
    end else begin
      mt_sync_q  <= {mt_sync_q[0], macrotick};
      rx_sync_q  <= {rx_sync_q[0], rx_line};
      fes_sync_q <= {fes_sync_q[0], fes_error};
      crc_sync_q <= {crc_sync_q[0], crc_error};
      fe_sync_q  <= {fe_sync_q[0], frame_end};
      mt_prev_q  <= mt_sync_q[1];
    end
  end
  wire mt_inc = mt_sync_q[1] & ~mt_prev_q;

  // ==========================================================
  // Address decode helper
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return (addr == ofs);
  endfunction : reg_hit

  // ==========================================================
  // APB decode
  wire        acc    = psel & penable;
  logic       wipe_q;
  wire        is_ib  = reg_hit(paddr, OFS_IBDATA);
  wire        stall  = is_ib & wipe_q;
  // A raised pready blocks taking the same access twice
  wire        done   = acc & ~pready & ~stall;
  wire        wr     = done & pwrite;
  wire        known  = (paddr[1:0] == 2'b00) && (paddr <= OFS_IRQ_MASK);
  wire        wr_cmd = wr & reg_hit(paddr, OFS_CMD);
  wire        wr_tmr = wr & reg_hit(paddr, OFS_TIMER);
  wire        wr_tst = wr & reg_hit(paddr, OFS_TEST);
  wire        wr_ibr = wr & reg_hit(paddr, OFS_IBREQ);
  wire        wr_ib  = wr & is_ib;
  wire        wr_ist = wr & reg_hit(paddr, OFS_IRQ_STAT);
  wire        wr_msk = wr & reg_hit(paddr, OFS_IRQ_MASK);

  // ==========================================================
  // Control registers
  logic [1:0]  tmc_q;
  logic        pag1_q, pag2_q, txd_q, txen_q, swap_q;
  logic        run_q, cont_q;
  logic [15:0] period_q;
  logic [5:0]  ib_idx_q;
  wire  [1:0]  tmc_w = pwdata[TST_TMC_LSB +: 2];
  wire         normal_w = (tmc_q == TMC_NORMAL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmc_q    <= TMC_NORMAL;
      pag1_q   <= 1'b0;
      pag2_q   <= 1'b0;
      txd_q    <= 1'b1;
      txen_q   <= 1'b1;
      swap_q   <= 1'b0;
      cont_q   <= 1'b0;
      period_q <= TMR_RESET;
      ib_idx_q <= 6'd0;
    end else begin
      if (wr_tst) begin
        tmc_q  <= tmc_w;
        txd_q  <= pwdata[TST_TX_BIT];
        txen_q <= pwdata[TST_TXEN_BIT];
        // Outside normal mode only the accessible buffer's page moves
        if (normal_w || !swap_q)
          pag1_q <= pwdata[TST_PAG1_BIT];
        if (normal_w || swap_q)
          pag2_q <= pwdata[TST_PAG2_BIT];
      end
      if (wr_ibr && normal_w)
        swap_q <= ~swap_q;
      if (wr_tmr) begin
        cont_q   <= pwdata[TMR_CONT_BIT];
        period_q <= pwdata[TMR_CNT_LSB +: 16];
      end
      if (wr_ib)
        ib_idx_q <= ib_idx_q + 6'd1;
    end
  end

  // ==========================================================
  // Input buffers: buffer select, page select, entry
  // The wipe only times the flag; buffer contents are kept
  logic [31:0] ibuf_mem [2*2*PAGE_ENTRIES];
  wire         cur_pag = swap_q ? pag2_q : pag1_q;
  wire  [IB_ADDR_W-1:0] ib_addr = {swap_q, cur_pag, ib_idx_q};
  always_ff @(posedge pclk) begin
    if (wr_ib)
      ibuf_mem[ib_addr] <= pwdata;
  end

  // ==========================================================
  // Relative timer
  typedef enum logic [2:0] {
    TMR_IDLE  = 3'b001,
    TMR_ARMED = 3'b010,
    TMR_COUNT = 3'b100
  } frtt_tmr_t;
  frtt_tmr_t   tmr_q, tmr_d;
  logic [15:0] mt_cnt_q, bclk_cnt_q, first_len_q;
  logic        first_q, tick_q;
  wire         run_w  = pwdata[TMR_RUN_BIT];
  wire         stop_w = wr_tmr & ~run_w;
  wire         mt_end = (mt_cnt_q + 16'd1 >= period_q);
  wire         fire   = (tmr_q == TMR_COUNT) &&
                        (first_q ? (mt_inc & mt_end)
                                 : (bclk_cnt_q + 16'd1 >= first_len_q));
  always_comb begin
    tmr_d = tmr_q;
    case (tmr_q)
      TMR_IDLE:  if (wr_tmr && run_w) tmr_d = TMR_ARMED;
      TMR_ARMED: if (stop_w) tmr_d = TMR_IDLE;
                 else if (mt_inc) tmr_d = TMR_COUNT;
      // A stop write wins over a fire in the same cycle
      TMR_COUNT: if (stop_w || (fire && !cont_q)) tmr_d = TMR_IDLE;
      default:   tmr_d = TMR_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q       <= TMR_IDLE;
      mt_cnt_q    <= TMR_RESET;
      bclk_cnt_q  <= TMR_RESET;
      first_len_q <= TMR_RESET;
      first_q     <= 1'b1;
      tick_q      <= 1'b0;
      run_q       <= 1'b0;
    end else begin
      tmr_q  <= tmr_d;
      tick_q <= fire;
      run_q  <= (tmr_d != TMR_IDLE);
      if (tmr_q != TMR_COUNT) begin
        mt_cnt_q    <= TMR_RESET;
        bclk_cnt_q  <= TMR_RESET;
        first_q     <= 1'b1;
      end else if (fire) begin
        // First period measured in clocks, later ones replay it exactly
        if (first_q)
          first_len_q <= bclk_cnt_q + 16'd1;
        first_q    <= 1'b0;
        bclk_cnt_q <= TMR_RESET;
      end else begin
        bclk_cnt_q <= bclk_cnt_q + 16'd1;
        if (mt_inc)
          mt_cnt_q <= mt_cnt_q + 16'd1;
      end
    end
  end

  // ==========================================================
  // Receive majority vote and activity observation
  logic [2:0] rx_hist_q;
  logic       rx_vote_q, active_q;
  logic [3:0] idle_cnt_q;
  // Three samples vote, so a one-sample glitch is filtered out
  wire        vote = (rx_hist_q[0] & rx_hist_q[1]) |
                     (rx_hist_q[1] & rx_hist_q[2]) |
                     (rx_hist_q[0] & rx_hist_q[2]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hist_q  <= 3'b111;
      rx_vote_q  <= 1'b1;
      active_q   <= 1'b0;
      idle_cnt_q <= 4'd0;
    end else begin
      rx_hist_q <= {rx_hist_q[1:0], rx_sync_q[1]};
      rx_vote_q <= vote;
      // Bus idle after a run of recessive samples
      if (!rx_vote_q) begin
        active_q   <= 1'b1;
        idle_cnt_q <= 4'd0;
      end else if (idle_cnt_q == 4'hF) begin
        active_q <= 1'b0;
      end else begin
        idle_cnt_q <= idle_cnt_q + 4'd1;
      end
    end
  end

  // ==========================================================
  // Coding error report
  logic [1:0] cerr_q;
  logic       fe_prev_q;
  wire        fe_evt = fe_sync_q[1] & ~fe_prev_q;
  wire  [1:0] cerr_w = fes_sync_q[1] ? CERR_FES :
                       crc_sync_q[1] ? CERR_CRC : CERR_NONE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cerr_q    <= CERR_NONE;
      fe_prev_q <= 1'b0;
    end else begin
      fe_prev_q <= fe_sync_q[1];
      if (fe_evt)
        cerr_q <= cerr_w;
    end
  end

  // ==========================================================
  // RAM wipe: runs from reset and on the wipe command
  logic [11:0] wipe_cnt_q;
  wire         wipe_cmd = wr_cmd & (pwdata[3:0] == CMD_WIPE);
  wire         wipe_end = wipe_q & (wipe_cnt_q == WIPE_LAST);
  // A new command restarts the count, even in mid-wipe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wipe_q     <= 1'b1;
      wipe_cnt_q <= 12'd0;
    end else if (wipe_cmd) begin
      wipe_q     <= 1'b1;
      wipe_cnt_q <= 12'd0;
    end else if (wipe_end) begin
      wipe_q <= 1'b0;
    end else if (wipe_q) begin
      wipe_cnt_q <= wipe_cnt_q + 12'd1;
    end
  end

  // ==========================================================
  // Interrupts: set wins over write-one clear
  logic [IRQ_W-1:0] ist_q, imsk_q;
  wire  [IRQ_W-1:0] iset = {fe_evt & (cerr_w != CERR_NONE), wipe_end, fire};
  // Mask gates only the line; status bits always record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q  <= '0;
      imsk_q <= '0;
      irq    <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~(wr_ist ? pwdata[IRQ_W-1:0] : '0)) | iset;
      if (wr_msk)
        imsk_q <= pwdata[IRQ_W-1:0];
      irq <= |(ist_q & imsk_q);
    end
  end

  // ==========================================================
  // Read mux and bus answer
  logic [31:0] rmux;
  always_comb begin
    rmux = ZERO_WORD;
    case (paddr)
      OFS_STATUS: begin
        rmux[ST_WIPE_BIT] = wipe_q;
        rmux[ST_ACT_BIT]  = active_q;
        rmux[ST_SWAP_BIT] = swap_q;
        rmux[ST_CERR_LSB +: 2] = cerr_q;
      end
      OFS_TIMER: begin
        rmux[TMR_RUN_BIT]  = run_q;
        rmux[TMR_CONT_BIT] = cont_q;
        rmux[TMR_CNT_LSB +: 16] = period_q;
      end
      OFS_TEST: begin
        rmux[TST_TMC_LSB +: 2] = tmc_q;
        rmux[TST_PAG1_BIT] = pag1_q;
        rmux[TST_PAG2_BIT] = pag2_q;
        rmux[TST_TX_BIT]   = txd_q;
        rmux[TST_TXEN_BIT] = txen_q;
      end
      OFS_IBDATA:   rmux = ibuf_mem[ib_addr];
      OFS_IRQ_STAT: rmux[IRQ_W-1:0] = ist_q;
      OFS_IRQ_MASK: rmux[IRQ_W-1:0] = imsk_q;
      default:      rmux = ZERO_WORD;
    endcase
  end

  // Read data only in the answer cycle, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= ZERO_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      timer_tick <= 1'b0;
      channel_transmit_line        <= 1'b1;
      channel_transmit_enable_line <= 1'b1;
    end else begin
      pready  <= done;
      pslverr <= done & ~known;
      prdata  <= (done && !pwrite) ? rmux : ZERO_WORD;
      timer_tick <= tick_q;
      // I/O test mode drives the lines from software bits
      channel_transmit_line        <= (tmc_q == TMC_IOTEST) ? txd_q : 1'b1;
      channel_transmit_enable_line <= (tmc_q == TMC_IOTEST) ? txen_q : 1'b1;
    end
  end

endmodule : frtt_core
`default_nettype wire

/* verif/frtt_properties.sv */
// Checker: port-level properties of the test and timing block
`default_nettype none
module frtt_properties
  import frtt_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        macrotick,
  input wire logic        rx_line,
  input wire logic        fes_error,
  input wire logic        crc_error,
  input wire logic        frame_end,
  input wire logic        channel_transmit_line,
  input wire logic        channel_transmit_enable_line,
  input wire logic        timer_tick,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Helper: cycles since reset release, saturating
  logic [11:0] up_q;
  wire         wr_test = psel & penable & pwrite & (paddr == OFS_TEST);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) up_q <= 12'h000;
    else if (up_q != 12'hFFF) up_q <= up_q + 12'h001;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access");
  AST_RD_IDLE: assert property (!pready |-> prdata == ZERO_WORD)
    else $error("prdata nonzero outside pready");
  AST_TICK_PULSE: assert property (timer_tick |=> !timer_tick)
    else $error("timer tick longer than one cycle");
  AST_TX_RELEASE: assert property (!$past(presetn) |->
    channel_transmit_line && channel_transmit_enable_line)
    else $error("transmit lines active after reset");
  AST_TX_CAUSE: assert property (($changed(channel_transmit_line) ||
    $changed(channel_transmit_enable_line)) |->
    ($past(wr_test) || $past(wr_test, 2)))
    else $error("transmit lines changed without test write");
  AST_IB_STALL: assert property ((pready && paddr == OFS_IBDATA) |->
    up_q >= 12'(WIPE_CYCLES))
    else $error("buffer access answered during wipe");
  cover property (timer_tick);
  cover property (pslverr);
  cover property (irq);
endmodule : frtt_properties

bind frtt_core frtt_properties chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .macrotick(macrotick), .rx_line(rx_line), .fes_error(fes_error),
  .crc_error(crc_error), .frame_end(frame_end),
  .channel_transmit_line(channel_transmit_line),
  .channel_transmit_enable_line(channel_transmit_enable_line),
  .timer_tick(timer_tick), .irq(irq));
`default_nettype wire

/* verif/frtt_xcvr_model.sv */
// Transceiver model: transmit looped back to receive two clocks late
`default_nettype none
module frtt_xcvr_model (
  input  wire logic pclk,
  input  wire logic txd,
  input  wire logic txen_n,
  output wire logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic d1_q = 1'b1;
  logic d2_q = 1'b1;
  // Disabled driver leaves the bus recessive, which is high
  always @(posedge pclk) begin
    d1_q <= txen_n | txd;
    d2_q <= d1_q;
  end
  assign rxd = d2_q;
endmodule : frtt_xcvr_model
`default_nettype wire

/* verif/tb_top.sv */
// Testbench: register access, wipe, buffers, test mux, timer, errors
`default_nettype none
module tb_top import frtt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, re;
  logic        macrotick, rx_line, fes_error, crc_error, frame_end;
  logic        tx, txen_n, timer_tick, irq, mt_en;
  logic [3:0]  mt_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, wd;
  logic [31:0] seed = 32'h0000_005E;
  int          cyc, failures, comparisons, t0, p, tt[3];
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s exp %0h got %0h", n, e, g); end end

  frtt_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .macrotick(macrotick), .rx_line(rx_line), .fes_error(fes_error),
    .crc_error(crc_error), .frame_end(frame_end),
    .channel_transmit_line(tx), .channel_transmit_enable_line(txen_n),
    .timer_tick(timer_tick), .irq(irq));
  frtt_xcvr_model xcvr_u (.pclk(pclk), .txd(tx), .txen_n(txen_n),
    .rxd(rx_line));

  always #10 pclk = ~pclk;
  // Three wipes plus traffic stay well below this ceiling
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      failures++;
      end_sim();
    end
  end
  // Macrotick of ten clocks, started only for the timer test
  always @(posedge pclk) begin
    if (mt_en) begin
      mt_q      <= (mt_q == 4'h9) ? 4'h0 : mt_q + 4'h1;
      macrotick <= (mt_q < 4'h5);
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [1:0] cerr_exp(input logic c, input logic f);
    return f ? CERR_FES : (c ? CERR_CRC : CERR_NONE);
  endfunction : cerr_exp

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic done(input string s);
    $display("test %s ended", s);
  endtask : done

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {macrotick, fes_error, crc_error, frame_end, mt_en, mt_q} = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("wipe busy", 1'b1, rv[ST_WIPE_BIT])
    while (rv[ST_WIPE_BIT] === 1'b1) apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("wipe len", 1'b1, (cyc - t0) inside {[2049:2062]})
    apb(1'b0, OFS_IRQ_STAT, ZERO_WORD);
    `CK("wipe event", 1'b1, rv[IRQ_WIPE_BIT])
    `CK("irq masked", 1'b0, irq)
    apb(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
    `CK("irq", 1'b1, irq)
    apb(1'b1, OFS_IRQ_STAT, 32'h0000_0002);
    `CK("irq clear", 1'b0, irq)
    apb(1'b0, 8'h20, ZERO_WORD);
    `CK("slverr", 1'b1, re)
    `CK("unmapped", ZERO_WORD, rv)
    done("reset wipe");
    // ==========================================================
    // Pages and buffer swap
    // Sixty-four writes bring the entry index back to the first word
    wd = rnd();
    apb(1'b1, OFS_IBDATA, wd);
    repeat (PAGE_ENTRIES - 1) apb(1'b1, OFS_IBDATA, rnd());
    apb(1'b0, OFS_IBDATA, ZERO_WORD);
    `CK("entry wrap", wd, rv)
    apb(1'b1, OFS_TEST, 32'h0000_0030);
    apb(1'b0, OFS_TEST, ZERO_WORD);
    `CK("pages", 2'b11, rv[5:4])
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("swap0", 1'b0, rv[ST_SWAP_BIT])
    apb(1'b1, OFS_IBREQ, rnd());
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("swap1", 1'b1, rv[ST_SWAP_BIT])
    apb(1'b1, OFS_TEST, 32'h0000_0001);
    apb(1'b1, OFS_TEST, 32'h0000_0031);
    apb(1'b1, OFS_IBREQ, rnd());
    apb(1'b0, OFS_TEST, ZERO_WORD);
    `CK("ram test page", 6'h21, rv[5:0])
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("no swap", 1'b1, rv[ST_SWAP_BIT])
    done("buffers");
    // ==========================================================
    // I/O test lines and activity
    repeat (4) begin
      wd = rnd() & 32'h0000_0300 | 32'h0000_0002;
      apb(1'b1, OFS_TEST, wd);
      `CK("tx lines", wd[9:8], {txen_n, tx})
    end
    apb(1'b1, OFS_TEST, ZERO_WORD);
    repeat (30) @(posedge pclk);
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("idle before", 1'b0, rv[ST_ACT_BIT])
    apb(1'b1, OFS_TEST, 32'h0000_0002);
    repeat (8) @(posedge pclk);
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("busy", 1'b1, rv[ST_ACT_BIT])
    apb(1'b1, OFS_TEST, ZERO_WORD);
    `CK("tx idle", 2'b11, {txen_n, tx})
    repeat (30) @(posedge pclk);
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("idle", 1'b0, rv[ST_ACT_BIT])
    done("io test");
    // A hardware reset also leaves a test mode, besides a write of normal mode
    apb(1'b1, OFS_TEST, 32'h0000_0002);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_TEST, ZERO_WORD);
    `CK("test exit", TMC_NORMAL, rv[1:0])
    `CK("tx released", 2'b11, {txen_n, tx})
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("rewipe", 1'b1, rv[ST_WIPE_BIT])
    done("test exit");
    for (int i = 0; i < 4; i++) begin
      crc_error <= i[0];
      fes_error <= i[1];
      @(posedge pclk);
      frame_end <= 1'b1;
      repeat (4) @(posedge pclk);
      frame_end <= 1'b0;
      apb(1'b0, OFS_STATUS, ZERO_WORD);
      `CK("cerr", cerr_exp(i[0], i[1]), rv[5:4])
    end
    apb(1'b0, OFS_IRQ_STAT, ZERO_WORD);
    `CK("cerr event", 1'b1, rv[IRQ_CERR_BIT])
    done("coding errors");
    // ==========================================================
    // Relative timer, continuous
    p = int'(rnd() % 4) + 1;
    mt_en <= 1'b1;
    apb(1'b1, OFS_TIMER, {p[15:0], 16'h0003});
    t0 = cyc;
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk iff timer_tick === 1'b1);
      tt[k] = cyc;
    end
    `CK("first", 1'b1, (tt[0] - t0) inside {[p*10-12:p*10+14]})
    `CK("period2", p * 10, tt[1] - tt[0])
    `CK("period3", p * 10, tt[2] - tt[1])
    apb(1'b1, OFS_TIMER, ZERO_WORD);
    apb(1'b0, OFS_TIMER, ZERO_WORD);
    `CK("stopped", 1'b0, rv[TMR_RUN_BIT])
    apb(1'b0, OFS_IRQ_STAT, ZERO_WORD);
    `CK("timer event", 1'b1, rv[IRQ_TIMER_BIT])
    done("timer");
    // ==========================================================
    // Host wipe command stalls the buffer window
    apb(1'b1, OFS_CMD, {28'h000_0000, CMD_WIPE});
    t0 = cyc;
    apb(1'b1, OFS_IBDATA, rnd());
    `CK("stall", 1'b1, (cyc - t0) >= 2040)
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    `CK("wipe done", 1'b0, rv[ST_WIPE_BIT])
    done("wipe cmd");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
